// ### src/puias_top.sv
/*
 power-up sequencer: internal reset, memory load, strap conversion, address
 forming, input lockout and conversion enable gating.
 assumes memory, converter, comparators and bus engine sit around it; the
 memory and converter run on ref_clk, supply and pin levels are asynchronous.
*/
`timescale 1ns/100ps
module puias_top
	import puias_pkg::*;
#(
	parameter logic [9:0] BIN_CODES = ADDR_BIN_CODES
) (
	// clock and reset
	input  wire logic            ref_clk,
	input  wire logic            rst_n,
	// supply monitors, asynchronous
	input  wire logic            vcc_good,
	input  wire logic            core_rail_pin,
	input  wire logic            osc_stable,
	// enable and input lockout comparators, asynchronous
	input  wire logic            enable_mode_pin,
	input  wire logic            vin_above_on,
	input  wire logic            vin_above_off,
	// multi_program_memory read port
	output puias_mem_rd_s        mem_rd_q,
	input  wire logic            mem_rd_valid,
	input  wire logic [7:0]      mem_rd_data,
	// strap converter
	output logic                 adc_start_q,
	input  wire logic            adc_done,
	input  wire logic [9:0]      adc_code,
	// input voltage telemetry
	input  wire logic [9:0]      vin_adc_code,
	output logic      [9:0]      read_vin_q,
	// bus engine side
	input  puias_cfg_wr_s        cfg_wr,
	input  puias_addr_req_s      addr_req,
	output logic                 addr_ack_q,
	output logic      [6:0]      i2c_addr_q,
	output logic      [6:0]      pmbus_addr_q,
	// status and controls
	output logic                 por_n_q,
	output logic                 init_done_q,
	output logic                 analog_mode_q,
	output logic      [2:0]      pin_analog_q,
	output logic      [7:0]      vin_on_thr_q,
	output logic      [7:0]      vin_off_thr_q,
	output logic                 conv_enable_q
);

	if (BIN_CODES == 10'h000 || ({4'h0, BIN_CODES} * 14'd16) > 14'd1023) begin : g_chk
		$error("BIN_CODES must leave room for sixteen bins and a floating code");
	end

	// synchronised asynchronous levels
	logic [5:0] raw_lvl;
	logic [5:0] lvl;
	assign raw_lvl = {vin_above_off, vin_above_on, enable_mode_pin,
		osc_stable, core_rail_pin, vcc_good};

	puias_sync #(.WIDTH(6)) u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.async_in (raw_lvl),
		.level_q  (lvl)
	);

	wire por_ok   = lvl[0] & lvl[1] & lvl[2];
	wire en_pin   = lvl[3];
	wire above_on = lvl[4];
	wire above_of = lvl[5];

	// state
	puias_state_e      state_q;
	puias_state_e      state_d;
	logic [IDX_W-1:0]  load_idx_q;
	logic [3:0]        offset_q;
	logic              lock_ok_q;
	logic [WORD_W-1:0] regs_q [NUM_WORDS];

	// strap decode: count bins passed, floating beyond the last
	logic [3:0] acc [NUM_OFFSETS];
	assign acc[0] = 4'h0;
	for (genvar g = 1; g < NUM_OFFSETS; g++) begin : g_bin
		localparam logic [13:0] EDGE = 14'(g) * {4'h0, BIN_CODES};
		assign acc[g] = acc[g-1] + 4'({3'h0, {4'h0, adc_code} >= EDGE});
	end
	wire [13:0] float_edge = 14'd16 * {4'h0, BIN_CODES};
	wire        strap_float = {4'h0, adc_code} >= float_edge;
	wire [3:0]  strap_off   = acc[NUM_OFFSETS-1];

	// sequencing decode
	wire in_run   = (state_q == ST_RUN) & por_ok;
	wire cfg_ok   = in_run & ~analog_mode_q;
	wire load_wr  = (state_q == ST_LOAD_WAIT) & mem_rd_valid;
	wire load_end = load_wr & (load_idx_q == IDX_LAST);
	wire host_wr  = cfg_wr.valid & cfg_ok;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_POR:       state_d = por_ok ? ST_LOAD_REQ : ST_POR;
			ST_LOAD_REQ:  state_d = ST_LOAD_WAIT;
			ST_LOAD_WAIT: state_d = load_end ? ST_ADC_REQ :
				(load_wr ? ST_LOAD_REQ : ST_LOAD_WAIT);
			ST_ADC_REQ:   state_d = ST_ADC_WAIT;
			ST_ADC_WAIT:  state_d = adc_done ? ST_RUN : ST_ADC_WAIT;
			ST_RUN:       state_d = ST_RUN;
			default:      state_d = ST_POR;
		endcase
		if (!por_ok) begin
			state_d = ST_POR;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= ST_POR;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n || state_q == ST_POR) begin
			load_idx_q <= '0;
		end else if (load_wr) begin
			load_idx_q <= load_idx_q + 3'h1;
		end
	end

	// working registers: one write port, loader or host
	wire [IDX_W-1:0]  wr_idx  = load_wr ? load_idx_q : cfg_wr.idx;
	wire [WORD_W-1:0] wr_data = load_wr ? mem_rd_data : cfg_wr.data;
	wire              wr_en   = load_wr | host_wr;

	for (genvar w = 0; w < NUM_WORDS; w++) begin : g_reg
		localparam logic [7:0] RV = (w == int'(IDX_VIN_ON))  ? RST_VIN_ON :
			(w == int'(IDX_VIN_OFF)) ? RST_VIN_OFF : RST_WORD;
		always_ff @(posedge ref_clk) begin
			if (!rst_n || !por_ok) begin
				regs_q[w] <= RV;
			end else if (wr_en && wr_idx == IDX_W'(w)) begin
				regs_q[w] <= wr_data;
			end
		end
	end

	// base addresses, seven bits each
	wire [6:0] i2c_base = regs_q[IDX_I2C_BASE][6:0];
	wire [6:0] pmb_base = regs_q[IDX_PMBUS_BASE][6:0];
	wire [6:0] i2c_eff  = i2c_base + {3'h0, offset_q};
	wire [6:0] pmb_eff  = pmb_base + {3'h0, offset_q};

	// strap capture
	always_ff @(posedge ref_clk) begin
		if (!rst_n || state_q == ST_POR) begin
			offset_q      <= 4'h0;
			analog_mode_q <= 1'b0;
		end else if (state_q == ST_ADC_WAIT && adc_done) begin
			offset_q      <= strap_float ? 4'h0 : strap_off;
			analog_mode_q <= strap_float;
		end
	end

	// address match
	wire tgt_zero = addr_req.pmbus ? (pmb_base == 7'h00) : (i2c_base == 7'h00);
	wire tgt_hit  = addr_req.addr == (addr_req.pmbus ? pmb_eff : i2c_eff);
	wire ack_d    = addr_req.valid & in_run & ~analog_mode_q & ~tgt_zero & tgt_hit;

	// input lockout from comparators only
	wire lock_d = !above_of ? 1'b0 : (above_on ? 1'b1 : lock_ok_q);

	// enable gating
	puias_enopt_e enopt;
	assign enopt = analog_mode_q ? EN_OPT_DEFAULT :
		puias_enopt_e'(regs_q[IDX_EN_OPTION][1:0]);
	wire sw_on = regs_q[IDX_SW_ON][0];
	logic gate_ok;
	always_comb begin
		case (enopt)
			EN_OPT_SOFTWARE:   gate_ok = sw_on;
			EN_OPT_PIN_AND_SW: gate_ok = sw_on & en_pin;
			default:           gate_ok = en_pin;
		endcase
	end
	wire conv_d = in_run & lock_ok_q & gate_ok;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lock_ok_q     <= 1'b0;
			conv_enable_q <= 1'b0;
			addr_ack_q    <= 1'b0;
		end else begin
			lock_ok_q     <= lock_d;
			conv_enable_q <= conv_d;
			addr_ack_q    <= ack_d;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			por_n_q     <= 1'b0;
			init_done_q <= 1'b0;
			mem_rd_q    <= '0;
			adc_start_q <= 1'b0;
		end else begin
			por_n_q       <= por_ok;
			init_done_q   <= (state_d == ST_RUN);
			mem_rd_q.req  <= (state_q == ST_LOAD_REQ);
			mem_rd_q.addr <= load_idx_q;
			adc_start_q   <= (state_q == ST_ADC_REQ);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			i2c_addr_q    <= 7'h00;
			pmbus_addr_q  <= 7'h00;
			pin_analog_q  <= 3'h0;
			vin_on_thr_q  <= RST_VIN_ON;
			vin_off_thr_q <= RST_VIN_OFF;
			read_vin_q    <= 10'h000;
		end else begin
			i2c_addr_q    <= i2c_eff;
			pmbus_addr_q  <= pmb_eff;
			pin_analog_q  <= {3{analog_mode_q}};
			vin_on_thr_q  <= regs_q[IDX_VIN_ON];
			vin_off_thr_q <= regs_q[IDX_VIN_OFF];
			read_vin_q    <= vin_adc_code;
		end
	end

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	wire [23:0] frozen_cfg = {regs_q[IDX_I2C_BASE], regs_q[IDX_PMBUS_BASE], regs_q[IDX_EN_OPTION]};

	property p_por_hold;
		!por_ok |=> !por_n_q && !init_done_q && !conv_enable_q;
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("released while supplies bad");

	property p_load_first;
		$rose(por_n_q) |=> mem_rd_q.req && mem_rd_q.addr == 3'h0;
	endproperty
	a_load_first: assert property (p_load_first) else $error("load did not start");

	property p_host_write;
		cfg_wr.valid && cfg_ok && cfg_wr.idx == IDX_SW_ON |=> regs_q[IDX_SW_ON] == $past(cfg_wr.data);
	endproperty
	a_host_write: assert property (p_host_write) else $error("host write lost");

	property p_conv_gate;
		conv_enable_q |-> $past(in_run) && $past(lock_ok_q);
	endproperty
	a_conv_gate: assert property (p_conv_gate) else $error("conversion without gating");

	property p_zero_base;
		addr_ack_q |-> $past(!tgt_zero);
	endproperty
	a_zero_base: assert property (p_zero_base) else $error("zero base acknowledged");

	property p_strap_once;
		adc_start_q |-> !init_done_q ##1 !adc_start_q;
	endproperty
	a_strap_once: assert property (p_strap_once) else $error("strap read outside init");

	property p_ack_addr;
		addr_ack_q |-> $past(addr_req.addr) == ($past(addr_req.pmbus) ? pmbus_addr_q : i2c_addr_q);
	endproperty
	a_ack_addr: assert property (p_ack_addr) else $error("ack on wrong address");

	property p_analog_quiet;
		analog_mode_q |=> !addr_ack_q && pin_analog_q == 3'h7;
	endproperty
	a_analog_quiet: assert property (p_analog_quiet) else $error("analog mode answered bus");

	property p_analog_frozen;
		analog_mode_q && in_run |=> $stable(frozen_cfg);
	endproperty
	a_analog_frozen: assert property (p_analog_frozen) else $error("analog config changed");

	property p_analog_enable;
		analog_mode_q && conv_enable_q |-> $past(en_pin);
	endproperty
	a_analog_enable: assert property (p_analog_enable) else $error("analog start without pin");

	property p_lockout;
		!above_of ##1 !above_of |=> !conv_enable_q;
	endproperty
	a_lockout: assert property (p_lockout) else $error("ran below lockout");

	property p_ack_ready;
		addr_ack_q |-> init_done_q && !analog_mode_q;
	endproperty
	a_ack_ready: assert property (p_ack_ready) else $error("ack before init done");

	property p_load_store;
		load_wr && por_ok |=> regs_q[$past(load_idx_q)] == $past(mem_rd_data);
	endproperty
	a_load_store: assert property (p_load_store) else $error("loaded word not stored");

	property p_sw_option;
		conv_enable_q && $past(enopt) == EN_OPT_SOFTWARE |-> $past(sw_on);
	endproperty
	a_sw_option: assert property (p_sw_option) else $error("software start ignored");

	property p_init_strap;
		$rose(init_done_q) |-> $past(adc_done) && $past(state_q) == ST_ADC_WAIT;
	endproperty
	a_init_strap: assert property (p_init_strap) else $error("init done without strap");

	property p_read_vin;
		por_n_q |=> read_vin_q == $past(vin_adc_code);
	endproperty
	a_read_vin: assert property (p_read_vin) else $error("input report not copied");

	c_digital_run: cover property (init_done_q && !analog_mode_q);
	c_analog_run:  cover property (init_done_q && analog_mode_q);
	c_ack:         cover property (addr_ack_q);
	c_convert:     cover property (conv_enable_q && enopt == EN_OPT_SOFTWARE);

endmodule : puias_top

// ### src/puias_pkg.sv
/*
 constants, types and enumerations of the power-up loader and address selector.
 assumes one 100 MHz clock with a synchronous active-low reset.
*/
// Functional notes
// - hold internal reset until supply, core rail and oscillator are all good
// - after reset, copy every memory word into the working registers
// - after loading, digital mode accepts host rewrites whatever the enable pin does
// - default start needs enable pin, input lockout cleared, load done, address read
// - keep separate 7-bit base addresses for the two buses
// - a base address of zero shuts that bus off
// - during start-up convert the strap pin to one of sixteen offsets
// - bus address is base plus strap offset, from +0 up to +15
// - digital mode answers bus traffic sent to base plus offset
// - a floating strap selects analog mode: no bus traffic, pins turned analog
// - analog mode freezes the loaded configuration
// - analog or default mode starts only on enable pin and input level together
// - lockout thresholds start at 1 V and may be reprogrammed by the host
// - the digitised input voltage only feeds the report, never the lockout
// - the input voltage report never affects feedforward
// - digital mode may pick software start options replacing the default gating
package puias_pkg;

	localparam int unsigned CLK_HZ       = 100_000_000;
	localparam int unsigned NUM_WORDS    = 8;
	localparam int unsigned WORD_W       = 8;
	localparam int unsigned IDX_W        = 3;
	localparam int unsigned ADC_W        = 10;
	localparam int unsigned NUM_OFFSETS  = 16;

	// working register indices
	localparam logic [2:0]  IDX_I2C_BASE   = 3'h0;
	localparam logic [2:0]  IDX_PMBUS_BASE = 3'h1;
	localparam logic [2:0]  IDX_EN_OPTION  = 3'h2;
	localparam logic [2:0]  IDX_VIN_ON     = 3'h3;
	localparam logic [2:0]  IDX_VIN_OFF    = 3'h4;
	localparam logic [2:0]  IDX_SW_ON      = 3'h5;
	localparam logic [2:0]  IDX_LAST       = 3'h7;

	// reset values of working registers, thresholds in 1/32 V steps
	localparam logic [7:0]  RST_WORD       = 8'h00;
	localparam logic [7:0]  RST_VIN_ON     = 8'h20;
	localparam logic [7:0]  RST_VIN_OFF    = 8'h20;

	// strap decode: width of one offset bin in converter codes
	localparam logic [9:0]  ADDR_BIN_CODES = 10'h03C;

	typedef enum logic [1:0] {
		EN_OPT_DEFAULT,
		EN_OPT_SOFTWARE,
		EN_OPT_PIN_AND_SW,
		EN_OPT_RESERVED
	} puias_enopt_e;

	typedef enum {
		ST_POR,
		ST_LOAD_REQ,
		ST_LOAD_WAIT,
		ST_ADC_REQ,
		ST_ADC_WAIT,
		ST_RUN
	} puias_state_e;

	typedef struct packed {
		logic             req;
		logic [IDX_W-1:0] addr;
	} puias_mem_rd_s;

	typedef struct packed {
		logic              valid;
		logic [IDX_W-1:0]  idx;
		logic [WORD_W-1:0] data;
	} puias_cfg_wr_s;

	typedef struct packed {
		logic       valid;
		logic       pmbus;
		logic [6:0] addr;
	} puias_addr_req_s;

endpackage : puias_pkg

// ### src/puias_sync.sv
/*
 three-stage input synchroniser; a change is taken once stages two and three agree.
 assumes inputs are asynchronous to ref_clk.
*/
`timescale 1ns/100ps
module puias_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	// raw and filtered levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] level_q
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	wire  [WIDTH-1:0] agree = ~(s2_q ^ s3_q);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			level_q <= '0;
		end else begin
			s1_q    <= async_in;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= (agree & s3_q) | (~agree & level_q);
		end
	end

endmodule : puias_sync

// ### verification/puias_mem_model.sv
/*
 memory and strap converter responder for the power-up loader.
 assumes requests are one-cycle pulses on ref_clk; lat sets the answer delay.
*/
`timescale 1ns/100ps
module puias_mem_model
	import puias_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	// settings from the bench
	input  wire logic [63:0] mem_img,
	input  wire logic [9:0]  strap_code,
	input  wire logic [2:0]  lat,
	// memory port
	input  puias_mem_rd_s    mem_rd,
	output logic             mem_rd_valid,
	output logic [7:0]       mem_rd_data,
	// converter port
	input  wire logic        adc_start,
	output logic             adc_done,
	output logic [9:0]       adc_code
);
	logic [3:0] mem_cnt_q;
	logic [3:0] adc_cnt_q;
	logic [2:0] mem_addr_q;

	// data lines toggle outside an answer, so stale values never look good
	always_ff @(posedge ref_clk) begin
		mem_rd_valid <= 1'b0;
		adc_done     <= 1'b0;
		mem_rd_data  <= ~mem_rd_data;
		adc_code     <= ~adc_code;
		if (!rst_n) begin
			mem_cnt_q   <= 4'h0;
			adc_cnt_q   <= 4'h0;
			mem_addr_q  <= 3'h0;
			mem_rd_data <= 8'hA5;
			adc_code    <= 10'h2AA;
		end else begin
			if (mem_rd.req) begin
				mem_cnt_q  <= {1'b0, lat} + 4'h1;
				mem_addr_q <= mem_rd.addr;
			end else if (mem_cnt_q != 4'h0) mem_cnt_q <= mem_cnt_q - 4'h1;
			if (mem_cnt_q == 4'h1 && !mem_rd.req) begin
				mem_rd_valid <= 1'b1;
				mem_rd_data  <= mem_img[mem_addr_q*8 +: 8];
			end
			if (adc_start) adc_cnt_q <= {1'b0, lat} + 4'h1;
			else if (adc_cnt_q != 4'h0) adc_cnt_q <= adc_cnt_q - 4'h1;
			if (adc_cnt_q == 4'h1 && !adc_start) begin
				adc_done <= 1'b1;
				adc_code <= strap_code;
			end
		end
	end
endmodule : puias_mem_model

// ### verification/tb.sv
/*
 self-checking bench for the power-up loader and address selector.
 assumes the memory and converter model stands on the far side.
*/
`timescale 1ns/100ps
module tb
	import puias_pkg::*;
;
	logic            ref_clk, rst_n, vcc_good, core_rail_pin, osc_stable;
	logic            enable_mode_pin, vin_above_on, vin_above_off;
	puias_mem_rd_s   mem_rd_q;
	logic            mem_rd_valid, adc_start_q, adc_done;
	logic [7:0]      mem_rd_data;
	logic [9:0]      adc_code, vin_adc_code, read_vin_q, strap_code;
	puias_cfg_wr_s   cfg_wr;
	puias_addr_req_s addr_req;
	logic            addr_ack_q, por_n_q, init_done_q, analog_mode_q, conv_enable_q;
	logic [6:0]      i2c_addr_q, pmbus_addr_q;
	logic [2:0]      pin_analog_q, lat;
	logic [7:0]      vin_on_thr_q, vin_off_thr_q;
	int              num_errors, num_checks;

	puias_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .vcc_good(vcc_good),
		.core_rail_pin(core_rail_pin), .osc_stable(osc_stable),
		.enable_mode_pin(enable_mode_pin), .vin_above_on(vin_above_on),
		.vin_above_off(vin_above_off), .mem_rd_q(mem_rd_q), .mem_rd_valid(mem_rd_valid),
		.mem_rd_data(mem_rd_data), .adc_start_q(adc_start_q), .adc_done(adc_done),
		.adc_code(adc_code), .vin_adc_code(vin_adc_code), .read_vin_q(read_vin_q),
		.cfg_wr(cfg_wr), .addr_req(addr_req), .addr_ack_q(addr_ack_q),
		.i2c_addr_q(i2c_addr_q), .pmbus_addr_q(pmbus_addr_q), .por_n_q(por_n_q),
		.init_done_q(init_done_q), .analog_mode_q(analog_mode_q),
		.pin_analog_q(pin_analog_q), .vin_on_thr_q(vin_on_thr_q),
		.vin_off_thr_q(vin_off_thr_q), .conv_enable_q(conv_enable_q));
	puias_mem_model mem (.ref_clk(ref_clk), .rst_n(rst_n),
		.mem_img(64'h0000_0038_4000_3020), .strap_code(strap_code), .lat(lat),
		.mem_rd(mem_rd_q), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
		.adc_start(adc_start_q), .adc_done(adc_done), .adc_code(adc_code));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic settle;
		repeat (8) @(negedge ref_clk);
	endtask : settle

	task automatic wr(input logic [2:0] idx, input logic [7:0] d);
		cfg_wr = '{1'b1, idx, d};
		@(negedge ref_clk);
		cfg_wr = '0;
		@(negedge ref_clk);
	endtask : wr

	task automatic send_addr(input logic pm, input logic [6:0] a, input logic exp);
		addr_req = '{1'b1, pm, a};
		@(negedge ref_clk);
		addr_req = '0;
		chk(addr_ack_q, exp);
		@(negedge ref_clk);
		chk(addr_ack_q, 1'b0);
	endtask : send_addr

	task automatic pwr_up(input logic [9:0] code, input logic [2:0] l, input logic [6:0] a);
		int n;
		strap_code = code;
		lat = l;
		vcc_good = 1'b1;
		osc_stable = 1'b1;
		settle();
		chk(por_n_q, 1'b0);
		core_rail_pin = 1'b1;
		addr_req = '{1'b1, 1'b0, a};
		n = 0;
		while (init_done_q !== 1'b1 && n < 300) begin
			@(negedge ref_clk);
			if (init_done_q !== 1'b1) chk(addr_ack_q, 1'b0);
			if (init_done_q !== 1'b1) chk(conv_enable_q, 1'b0);
			n++;
		end
		addr_req = '0;
		chk(init_done_q, 1'b1);
		repeat (2) @(negedge ref_clk);
	endtask : pwr_up

	task automatic pwr_down;
		vcc_good = 1'b0;
		core_rail_pin = 1'b0;
		settle();
		chk(init_done_q, 1'b0);
		chk(vin_on_thr_q, 8'h20);
	endtask : pwr_down

	task automatic t_digital;
		pwr_up(10'h0B4, 3'h2, 7'h23);
		chk(i2c_addr_q, 7'h23);
		chk(pmbus_addr_q, 7'h33);
		chk(vin_on_thr_q, 8'h40);
		chk(vin_off_thr_q, 8'h38);
		chk(analog_mode_q, 1'b0);
		send_addr(1'b0, 7'h23, 1'b1);
		send_addr(1'b1, 7'h33, 1'b1);
		send_addr(1'b0, 7'h24, 1'b0);
		send_addr(1'b1, 7'h23, 1'b0);
	endtask : t_digital

	task automatic t_cfg;
		wr(IDX_VIN_ON, 8'h50);
		chk(vin_on_thr_q, 8'h50);
		wr(IDX_VIN_OFF, 8'h48);
		chk(vin_off_thr_q, 8'h48);
		wr(IDX_I2C_BASE, 8'h00);
		send_addr(1'b0, 7'h03, 1'b0);
		send_addr(1'b1, 7'h33, 1'b1);
		wr(IDX_PMBUS_BASE, 8'h10);
		chk(pmbus_addr_q, 7'h13);
		send_addr(1'b1, 7'h13, 1'b1);
		wr(IDX_I2C_BASE, 8'h7E);
		send_addr(1'b0, 7'h01, 1'b1);
	endtask : t_cfg

	task automatic t_enable;
		vin_above_on = 1'b1;
		vin_above_off = 1'b1;
		settle();
		chk(conv_enable_q, 1'b0);
		enable_mode_pin = 1'b1;
		settle();
		chk(conv_enable_q, 1'b1);
		vin_above_on = 1'b0;
		settle();
		chk(conv_enable_q, 1'b1);
		vin_above_off = 1'b0;
		vin_adc_code = 10'h3FF;
		settle();
		chk(conv_enable_q, 1'b0);
		chk(read_vin_q, 10'h3FF);
		vin_above_on = 1'b1;
		vin_above_off = 1'b1;
		settle();
		wr(IDX_EN_OPTION, 8'h01);
		wr(IDX_SW_ON, 8'h00);
		chk(conv_enable_q, 1'b0);
		wr(IDX_SW_ON, 8'h01);
		chk(conv_enable_q, 1'b1);
		enable_mode_pin = 1'b0;
		settle();
		chk(conv_enable_q, 1'b1);
		wr(IDX_EN_OPTION, 8'h02);
		chk(conv_enable_q, 1'b0);
		wr(IDX_EN_OPTION, 8'h03);
		chk(conv_enable_q, 1'b0);
		enable_mode_pin = 1'b1;
		settle();
		chk(conv_enable_q, 1'b1);
	endtask : t_enable

	task automatic t_analog;
		pwr_down();
		pwr_up(10'h3BF, 3'h0, 7'h2F);
		chk(i2c_addr_q, 7'h2F);
		chk(vin_on_thr_q, 8'h40);
		pwr_down();
		pwr_up(10'h3C0, 3'h5, 7'h20);
		chk(analog_mode_q, 1'b1);
		chk(pin_analog_q, 3'h7);
		send_addr(1'b0, 7'h20, 1'b0);
		send_addr(1'b1, 7'h30, 1'b0);
		wr(IDX_VIN_ON, 8'h55);
		chk(vin_on_thr_q, 8'h40);
		enable_mode_pin = 1'b0;
		settle();
		chk(conv_enable_q, 1'b0);
		enable_mode_pin = 1'b1;
		settle();
		chk(conv_enable_q, 1'b1);
		vin_above_on = 1'b0;
		vin_above_off = 1'b0;
		settle();
		chk(conv_enable_q, 1'b0);
	endtask : t_analog

	initial begin
		int cyc;
		for (cyc = 0; cyc < 20000; cyc++) @(posedge ref_clk);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		{rst_n, vcc_good, core_rail_pin, osc_stable} = 4'h0;
		{enable_mode_pin, vin_above_on, vin_above_off} = 3'h0;
		{vin_adc_code, strap_code, lat} = 23'h0;
		cfg_wr = '0;
		addr_req = '0;
		num_errors = 0;
		num_checks = 0;
		repeat (3) @(negedge ref_clk);
		rst_n = 1'b1;
		t_digital();
		t_cfg();
		t_enable();
		t_analog();
		tally_and_finish();
	end
endmodule : tb
